// >>> rtl/wtu_watchdog.v
`timescale 1ns/100ps
`include "wtu_map.vh"

module wtu_watchdog #(
   parameter AW = 16
) (
   input  wire          i_clk,
   input  wire          i_reset_n,
   input  wire          i_osc_clk,
   input  wire          i_timeout_response_option,
   input  wire          i_always_on,
   input  wire          i_psel,
   input  wire          i_penable,
   input  wire          i_pwrite,
   input  wire [AW-1:0] i_paddr,
   input  wire [31:0]   i_pwdata,
   output reg  [31:0]   o_prdata,
   output reg           o_pready,
   output reg           o_pslverr,
   output reg           o_timeout_irq,
   output reg           o_system_reset,
   output reg           o_irq
);

   // ------------------------------------------------------------------------
   // Address decode helpers
   // ------------------------------------------------------------------------
   // Word aligned access to one of the seven indices
   function wtu_mapped;
      input [AW-1:0] addr;
      reg   [11:0]   idx;
      begin
         idx = addr[13:2];
         wtu_mapped = (addr[1:0] == 2'h0) && (addr[AW-1:14] == {(AW-14){1'b0}}) &&
                      (idx == `WTU_IDX_RESET_STATUS || idx == `WTU_IDX_RELOAD_UPPER ||
                       idx == `WTU_IDX_RELOAD_HIGH  || idx == `WTU_IDX_RELOAD_LOW   ||
                       idx == `WTU_IDX_IRQ_STATUS   || idx == `WTU_IDX_IRQ_MASK     ||
                       idx == `WTU_IDX_INFO);
      end
   endfunction

   function wtu_is;
      input [AW-1:0] addr;
      input [11:0]   idx;
      begin
         wtu_is = (addr[1:0] == 2'h0) && (addr[AW-1:14] == {(AW-14){1'b0}}) && (addr[13:2] == idx);
      end
   endfunction

   // ------------------------------------------------------------------------
   // System domain state
   // ------------------------------------------------------------------------
   reg  [7:0]  reload_upper_r;
   reg  [7:0]  reload_high_r;
   reg  [7:0]  reload_low_r;
   reg  [23:0] snap_r;
   reg         req_tgl_r;
   reg         ack_s1_r;
   reg         ack_s2_r;
   reg         busy_q_r;
   reg         pend_r;
   reg         boot_r;
   reg         tl_s1_r;
   reg         tl_s2_r;
   reg         tt_s1_r;
   reg         tt_s2_r;
   reg         tt_s3_r;
   reg         flag_r;
   reg  [1:0]  irq_status_r;
   reg  [1:0]  irq_mask_r;

   // ------------------------------------------------------------------------
   // Oscillator domain state
   // ------------------------------------------------------------------------
   reg         req_s1_r;
   reg         req_s2_r;
   reg         req_s3_r;
   reg         ack_tgl_r;
   reg  [23:0] cnt_r;
   reg         running_r;
   reg         tout_lvl_r;
   reg         tout_tgl_r;

   // ------------------------------------------------------------------------
   // Bus strobes and crossing events
   // ------------------------------------------------------------------------
   wire        setup    = i_psel & ~i_penable;
   wire        access   = i_psel & i_penable & o_pready;
   wire        wr       = access & i_pwrite;
   wire        rd       = access & ~i_pwrite;
   wire        busy     = req_tgl_r ^ ack_s2_r;
   wire        tout_evt = tt_s2_r ^ tt_s3_r;
   wire [23:0] reload   = {reload_upper_r, reload_high_r, reload_low_r};

   wire        wr_ctrl  = wr & wtu_is(i_paddr, `WTU_IDX_CONTROL);
   wire        rd_rstat = rd & wtu_is(i_paddr, `WTU_IDX_RESET_STATUS);
   wire        refresh  = wr_ctrl | (boot_r & i_always_on);
   wire        ref_done = busy_q_r & ~busy;

   // ------------------------------------------------------------------------
   // Read data mux
   // ------------------------------------------------------------------------
   reg  [31:0] rdata;
   always @* begin
      rdata = 32'h0;
      if (wtu_is(i_paddr, `WTU_IDX_RESET_STATUS)) begin
         rdata[`WTU_RSTAT_TIMEOUT_BIT] = flag_r;
      end else if (wtu_is(i_paddr, `WTU_IDX_RELOAD_UPPER)) begin
         rdata[7:0] = reload_upper_r;
      end else if (wtu_is(i_paddr, `WTU_IDX_RELOAD_HIGH)) begin
         rdata[7:0] = reload_high_r;
      end else if (wtu_is(i_paddr, `WTU_IDX_RELOAD_LOW)) begin
         rdata[7:0] = reload_low_r;
      end else if (wtu_is(i_paddr, `WTU_IDX_IRQ_STATUS)) begin
         rdata[1:0] = irq_status_r;
      end else if (wtu_is(i_paddr, `WTU_IDX_IRQ_MASK)) begin
         rdata[1:0] = irq_mask_r;
      end else if (wtu_is(i_paddr, `WTU_IDX_INFO)) begin
         rdata[`WTU_INFO_OPTION_BIT] = i_timeout_response_option;
         rdata[`WTU_INFO_BUSY_BIT]   = busy;
         rdata[`WTU_INFO_PEND_BIT]   = pend_r;
      end
   end

   // ------------------------------------------------------------------------
   // APB slave, one cycle of setup then an access completed at once
   // ------------------------------------------------------------------------
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata  <= 32'h0;
      end else begin
         o_pready  <= setup;
         o_pslverr <= setup & ~wtu_mapped(i_paddr);
         // Read data only in the ready cycle
         o_prdata  <= setup ? rdata : 32'h0;
      end
   end

   // ------------------------------------------------------------------------
   // Reload and mask registers
   // ------------------------------------------------------------------------
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         reload_upper_r <= `WTU_RST_RELOAD_UPPER;
         reload_high_r  <= `WTU_RST_RELOAD_HIGH;
         reload_low_r   <= `WTU_RST_RELOAD_LOW;
         irq_mask_r     <= `WTU_RST_IRQ_MASK;
      end else if (wr) begin
         if (wtu_is(i_paddr, `WTU_IDX_RELOAD_UPPER)) begin
            reload_upper_r <= i_pwdata[7:0];
         end
         if (wtu_is(i_paddr, `WTU_IDX_RELOAD_HIGH)) begin
            reload_high_r <= i_pwdata[7:0];
         end
         if (wtu_is(i_paddr, `WTU_IDX_RELOAD_LOW)) begin
            reload_low_r <= i_pwdata[7:0];
         end
         if (wtu_is(i_paddr, `WTU_IDX_IRQ_MASK)) begin
            irq_mask_r <= i_pwdata[1:0];
         end
      end
   end

   // ------------------------------------------------------------------------
   // Refresh request handshake toward the oscillator domain
   // ------------------------------------------------------------------------
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         req_tgl_r <= 1'b0;
         snap_r    <= 24'h0;
         pend_r    <= 1'b0;
         boot_r    <= 1'b1;
         ack_s1_r  <= 1'b0;
         ack_s2_r  <= 1'b0;
         busy_q_r  <= 1'b0;
      end else begin
         // Strap refresh only in the first cycle after reset
         boot_r   <= 1'b0;
         ack_s1_r <= ack_tgl_r;
         ack_s2_r <= ack_s1_r;
         busy_q_r <= busy;
         // Snapshot stays frozen until the far side acknowledges
         if (!busy && (refresh || pend_r)) begin
            req_tgl_r <= ~req_tgl_r;
            snap_r    <= reload;
            pend_r    <= 1'b0;
         end else if (refresh) begin
            pend_r <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------------
   // Timeout return path and responses
   // ------------------------------------------------------------------------
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         tl_s1_r        <= 1'b0;
         tl_s2_r        <= 1'b0;
         tt_s1_r        <= 1'b0;
         tt_s2_r        <= 1'b0;
         tt_s3_r        <= 1'b0;
         flag_r         <= 1'b0;
         irq_status_r   <= 2'h0;
         o_timeout_irq  <= 1'b0;
         o_system_reset <= 1'b0;
         o_irq          <= 1'b0;
      end else begin
         // Level path drives the outputs, toggle path the flags
         tl_s1_r <= tout_lvl_r;
         tl_s2_r <= tl_s1_r;
         tt_s1_r <= tout_tgl_r;
         tt_s2_r <= tt_s1_r;
         tt_s3_r <= tt_s2_r;
         o_timeout_irq  <= tl_s2_r & i_timeout_response_option;
         o_system_reset <= tl_s2_r & ~i_timeout_response_option;
         // Set wins over the read clear
         if (tout_evt) begin
            flag_r <= 1'b1;
         end else if (rd_rstat) begin
            flag_r <= 1'b0;
         end
         irq_status_r[`WTU_IRQ_TIMEOUT_BIT] <= tout_evt |
            (irq_status_r[`WTU_IRQ_TIMEOUT_BIT] &
             ~(wr & wtu_is(i_paddr, `WTU_IDX_IRQ_STATUS) & i_pwdata[`WTU_IRQ_TIMEOUT_BIT]));
         irq_status_r[`WTU_IRQ_REFRESH_BIT] <= ref_done |
            (irq_status_r[`WTU_IRQ_REFRESH_BIT] &
             ~(wr & wtu_is(i_paddr, `WTU_IDX_IRQ_STATUS) & i_pwdata[`WTU_IRQ_REFRESH_BIT]));
         o_irq <= |(irq_status_r & irq_mask_r);
      end
   end

   // ------------------------------------------------------------------------
   // Oscillator domain down-counter
   // ------------------------------------------------------------------------
   wire        go = req_s2_r ^ req_s3_r;
   reg  [23:0] cnt_nxt;
   reg         run_nxt;
   reg         tgl_nxt;

   always @* begin
      cnt_nxt = cnt_r;
      run_nxt = running_r;
      tgl_nxt = tout_tgl_r;
      // Late refresh dropped, its handshake still completes
      if (go && (!running_r || cnt_r > `WTU_REFRESH_FLOOR)) begin
         cnt_nxt = snap_r;
         run_nxt = 1'b1;
      end else if (running_r) begin
         if (cnt_r == `WTU_CNT_ZERO) begin
            cnt_nxt = `WTU_CNT_MAX;
         end else begin
            cnt_nxt = cnt_r - 24'h000001;
            if (cnt_nxt == `WTU_CNT_ZERO) begin
               tgl_nxt = ~tout_tgl_r;
            end
         end
      end
   end

   // ------------------------------------------------------------------------
   // Oscillator domain registers
   // ------------------------------------------------------------------------
   always @(posedge i_osc_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         req_s1_r   <= 1'b0;
         req_s2_r   <= 1'b0;
         req_s3_r   <= 1'b0;
         ack_tgl_r  <= 1'b0;
         cnt_r      <= 24'h0;
         running_r  <= 1'b0;
         tout_lvl_r <= 1'b0;
         tout_tgl_r <= 1'b0;
      end else begin
         req_s1_r   <= req_tgl_r;
         req_s2_r   <= req_s1_r;
         req_s3_r   <= req_s2_r;
         ack_tgl_r  <= req_s3_r;
         cnt_r      <= cnt_nxt;
         running_r  <= run_nxt;
         tout_tgl_r <= tgl_nxt;
         tout_lvl_r <= run_nxt & (cnt_nxt == `WTU_CNT_ZERO);
      end
   end

endmodule

// >>> rtl/wtu_map.vh
`ifndef WTU_MAP_VH
`define WTU_MAP_VH
// ---------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------------------
`define WTU_IDX_RESET_STATUS  12'hff0
`define WTU_IDX_CONTROL       12'hff0
`define WTU_IDX_RELOAD_UPPER  12'hff1
`define WTU_IDX_RELOAD_HIGH   12'hff2
`define WTU_IDX_RELOAD_LOW    12'hff3
`define WTU_IDX_IRQ_STATUS    12'h100
`define WTU_IDX_IRQ_MASK      12'h101
`define WTU_IDX_INFO          12'h102
// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define WTU_RST_RELOAD_UPPER  8'h00
`define WTU_RST_RELOAD_HIGH   8'h04
`define WTU_RST_RELOAD_LOW    8'h00
`define WTU_RST_IRQ_MASK      2'h0
// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define WTU_RSTAT_TIMEOUT_BIT 5
`define WTU_IRQ_TIMEOUT_BIT   0
`define WTU_IRQ_REFRESH_BIT   1
`define WTU_INFO_OPTION_BIT   0
`define WTU_INFO_BUSY_BIT     1
`define WTU_INFO_PEND_BIT     2
// ---------------------------------------------------------------------------
// Counter constants
// ---------------------------------------------------------------------------
`define WTU_CNT_MAX           24'hffffff
`define WTU_CNT_ZERO          24'h000000
`define WTU_REFRESH_FLOOR     24'h000002
`endif

// >>> verification/wtu_osc_model.sv
`timescale 1ns/100ps
// ---------------------------------------------
// Free running watchdog oscillator
// ---------------------------------------------
module wtu_osc_model #(
   parameter HALF_NS = 20
) (
   output logic o_osc_clk
);
   initial begin
      o_osc_clk = 1'b0;
      #7;
      forever #(HALF_NS) o_osc_clk = ~o_osc_clk;
   end
endmodule

// >>> verification/wtu_watchdog_sva.sv
`timescale 1ns/100ps
module wtu_watchdog_sva #(
   parameter AW = 16
) (
   input logic          i_clk,
   input logic          i_reset_n,
   input logic          i_timeout_response_option,
   input logic          i_psel,
   input logic          i_penable,
   input logic [AW-1:0] i_paddr,
   input logic          o_pready,
   input logic          o_pslverr,
   input logic [31:0]   o_prdata,
   input logic          o_timeout_irq,
   input logic          o_system_reset
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   sequence s_setup; i_psel && !i_penable; endsequence
   sequence s_access; i_psel && i_penable && o_pready; endsequence
   property p_ready_after_setup; s_setup |=> o_pready; endproperty
   a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");
   property p_ready_one_cycle; s_access |=> !o_pready; endproperty
   a_ready_one_cycle: assert property (p_ready_one_cycle) else $error("ready held too long");
   property p_no_stray_ready; !(i_psel && !i_penable) |=> !o_pready; endproperty
   a_no_stray_ready: assert property (p_no_stray_ready) else $error("stray ready");
   property p_err_misaligned; s_setup ##0 (i_paddr[1:0] != 2'h0) |=> o_pslverr && o_pready; endproperty
   a_err_misaligned: assert property (p_err_misaligned) else $error("misaligned not refused");
   property p_reload_mapped;
      s_setup ##0 (i_paddr == 16'h3fc4 || i_paddr == 16'h3fc8 || i_paddr == 16'h3fcc) |=> !o_pslverr;
   endproperty
   a_reload_mapped: assert property (p_reload_mapped) else $error("reload byte refused");
   property p_prdata_idle; !o_pready |-> o_prdata == 32'h0; endproperty
   a_prdata_idle: assert property (p_prdata_idle) else $error("read data outside access");
   property p_irq_needs_option; o_timeout_irq |-> i_timeout_response_option; endproperty
   a_irq_needs_option: assert property (p_irq_needs_option) else $error("irq in reset mode");
   property p_reset_needs_option; o_system_reset |-> !i_timeout_response_option; endproperty
   a_reset_needs_option: assert property (p_reset_needs_option) else $error("reset in irq mode");
   property p_irq_holds; $rose(o_timeout_irq) |=> o_timeout_irq [*4]; endproperty
   a_irq_holds: assert property (p_irq_holds) else $error("timeout irq too short");
   property p_irq_rolls_over; $rose(o_timeout_irq) |-> ##[1:100] !o_timeout_irq; endproperty
   a_irq_rolls_over: assert property (p_irq_rolls_over) else $error("timeout irq never ends");
endmodule
bind wtu_watchdog wtu_watchdog_sva #(.AW(AW)) i_sva (.i_clk(i_clk), .i_reset_n(i_reset_n),
   .i_timeout_response_option(i_timeout_response_option), .i_psel(i_psel), .i_penable(i_penable),
   .i_paddr(i_paddr), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_prdata(o_prdata),
   .o_timeout_irq(o_timeout_irq), .o_system_reset(o_system_reset));

// >>> verification/testbench.sv
`timescale 1ns/100ps
module testbench;
   logic        i_clk, i_reset_n, i_osc_clk, i_timeout_response_option, i_always_on;
   logic        i_psel, i_penable, i_pwrite, err, o_pready, o_pslverr, o_timeout_irq, o_system_reset, o_irq;
   logic [15:0] i_paddr;
   logic [31:0] i_pwdata, rd, o_prdata;
   int          error_cnt, n_checks, cyc;
   wtu_watchdog #(.AW(16)) i_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_osc_clk(i_osc_clk),
      .i_timeout_response_option(i_timeout_response_option), .i_always_on(i_always_on),
      .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
      .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
      .o_timeout_irq(o_timeout_irq), .o_system_reset(o_system_reset), .o_irq(o_irq));
   wtu_osc_model #(.HALF_NS(20)) i_osc (.o_osc_clk(i_osc_clk));
   // ---------------------------------------------
   // Tasks
   // ---------------------------------------------
   task report_and_stop;
      if (error_cnt == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      int n;
      @(posedge i_clk);
      i_psel <= 1'b1; i_pwrite <= w; i_paddr <= a; i_pwdata <= d; i_penable <= 1'b0;
      @(posedge i_clk);
      i_penable <= 1'b1;
      n = 0;
      do begin @(posedge i_clk); n++; end while (o_pready !== 1'b1 && n < 16);
      if (o_pready !== 1'b1) begin chk(32'h0, 32'h1); report_and_stop; end
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0; i_penable <= 1'b0;
   endtask
   task wait_evt(input int lim);
      cyc = 0;
      while (cyc < lim && o_timeout_irq !== 1'b1 && o_system_reset !== 1'b1) begin
         @(posedge i_clk);
         cyc++;
      end
   endtask
   task rst(input logic o, input logic a);
      i_reset_n <= 1'b0; i_timeout_response_option <= o; i_always_on <= a;
      repeat (10) @(posedge i_clk);
      i_reset_n <= 1'b1;
   endtask
   // ---------------------------------------------
   // Clock, hang limit, scenarios
   // ---------------------------------------------
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   initial begin
      repeat (50000) @(posedge i_clk);
      chk(32'h0, 32'h1);
      report_and_stop;
   end
   initial begin
      i_reset_n = 0; i_timeout_response_option = 1; i_always_on = 0; i_psel = 0; i_penable = 0;
      i_pwrite = 0; i_paddr = 16'h0; i_pwdata = 32'h0; error_cnt = 0; n_checks = 0;
      rst(1'b1, 1'b0);
      apb(0, 16'h3fc4, 0); chk(rd, 32'h0);
      apb(0, 16'h3fc8, 0); chk(rd, 32'h4);
      apb(0, 16'h3fcc, 0); chk(rd, 32'h0);
      apb(1, 16'h3fc4, 32'h5a); apb(1, 16'h3fc8, 32'ha5); apb(1, 16'h3fcc, 32'h3c);
      apb(0, 16'h3fc4, 0); chk(rd, 32'h5a);
      apb(0, 16'h3fc8, 0); chk(rd, 32'ha5);
      apb(0, 16'h3fcc, 0); chk(rd, 32'h3c);
      apb(0, 16'h3fd0, 0); chk({rd[31:1], err}, 32'h1);
      apb(0, 16'h3fc5, 0); chk({31'h0, err}, 32'h1);
      apb(0, 16'h0408, 0); chk({31'h0, rd[0]}, 32'h1);
      apb(1, 16'h3fc4, 0); apb(1, 16'h3fc8, 0); apb(1, 16'h3fcc, 32'h20);
      apb(0, 16'h3fc0, 0); chk({31'h0, rd[5]}, 32'h0);
      apb(1, 16'h3fc0, 0);
      apb(1, 16'h3fc0, 0);
      apb(0, 16'h0408, 0); chk({29'h0, rd[2:0]}, 32'h7);
      repeat (60) @(posedge i_clk);
      apb(0, 16'h0408, 0); chk({29'h0, rd[2:0]}, 32'h1);
      repeat (4) begin
         apb(1, 16'h3fc0, 0); wait_evt(80); chk(cyc, 80);
      end
      apb(1, 16'h3fc0, 0); wait_evt(400); chk(32'(cyc >= 150 && cyc <= 230), 32'h1);
      chk({o_timeout_irq, o_system_reset}, 32'h2);
      repeat (4) @(posedge i_clk);
      apb(0, 16'h3fc0, 0); chk({31'h0, rd[5]}, 32'h1);
      apb(0, 16'h3fc0, 0); chk({31'h0, rd[5]}, 32'h0);
      apb(0, 16'h0400, 0); chk(rd, 32'h3);
      chk({31'h0, o_irq}, 32'h0);
      apb(1, 16'h0404, 1); repeat (3) @(posedge i_clk); chk({31'h0, o_irq}, 32'h1);
      apb(1, 16'h0400, 1); repeat (3) @(posedge i_clk); chk({31'h0, o_irq}, 32'h0);
      apb(1, 16'h0404, 2); repeat (3) @(posedge i_clk); chk({31'h0, o_irq}, 32'h1);
      apb(1, 16'h0400, 2); repeat (3) @(posedge i_clk); chk({31'h0, o_irq}, 32'h0);
      apb(0, 16'h0404, 0); chk(rd, 32'h2);
      chk({31'h0, o_timeout_irq}, 32'h0); wait_evt(400); chk(cyc, 400);
      // Second refresh lands 31 or 32 oscillator edges after the first
      apb(1, 16'h3fc0, 0);
      repeat (154) @(posedge i_clk);
      apb(1, 16'h3fc0, 0);
      wait_evt(60);
      chk(32'(cyc < 60), 32'h1);
      chk({o_timeout_irq, o_system_reset}, 32'h2);
      rst(1'b0, 1'b1);
      wait_evt(6000); chk(32'(cyc >= 5100 && cyc <= 5250), 32'h1);
      chk({o_timeout_irq, o_system_reset}, 32'h1);
      report_and_stop;
   end
endmodule
